// ### logic/rsq_top.sv
// Reset sequencer with reset cause flags and an APB register slave.
`timescale 1ns/10ps
module rsq_top
  import rsq_pkg::*;
#(
  parameter int unsigned MS_CYCLES   = MS_CYC,
  parameter int unsigned LOCK_CYCLES = LOCK_CYC,
  parameter int unsigned FAIL_SAFE_CLOCK_MONITOR_CYCLES = FAIL_SAFE_CLOCK_MONITOR_CYC
) (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Analogue detector outputs.
  input  wire logic        por_active,
  input  wire logic        bor_active,
  // Warm reset sources and oscillator.
  input  wire logic        ext_reset,
  input  wire logic        soft_reset,
  input  wire logic        wdt_timeout,
  input  wire logic        osc_tick,
  // Configuration words.
  input  wire logic [2:0]  initial_clock_select,
  input  wire logic [2:0]  power_up_delay_select,
  input  wire logic        watchdog_fuse_enable,
  input  wire logic        fail_safe_clock_monitor_enable,
  // Sequencer outputs.
  output logic             system_reset,
  output logic             clock_ready,
  output logic             fetch_start,
  output logic [23:0]      fetch_addr,
  output logic             fail_safe_clock_monitor,
  output logic             watchdog_enable,
  output logic [2:0]       current_clock_select,
  output logic             irq
);

  initial begin
    if (MS_CYCLES < 1 || LOCK_CYCLES < 1 || FAIL_SAFE_CLOCK_MONITOR_CYCLES < 1)
      $error("rsq_top: cycle counts must be at least one");
  end

  // ==========================================================================
  // Synchronisers: three stages, change accepted when last two agree.
  logic [5:0] s1_ff, s2_ff, s3_ff, flt_ff;
  logic [5:0] raw;
  assign raw = {osc_tick, wdt_timeout, soft_reset, ext_reset,
                bor_active, por_active};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff  <= 6'h03;
      s2_ff  <= 6'h03;
      s3_ff  <= 6'h03;
      flt_ff <= 6'h03;
    end else begin
      s1_ff <= raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (int i = 0; i < 6; i++) begin
        if (s2_ff[i] == s3_ff[i])
          flt_ff[i] <= s3_ff[i];
      end
    end
  end

  logic por_s, bor_s, ext_s, swr_s, wdt_s, tick_s;
  assign {tick_s, wdt_s, swr_s, ext_s, bor_s, por_s} = flt_ff;

  logic por_d_ff, bor_d_ff, ext_d_ff, swr_d_ff, wdt_d_ff, tick_d_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_d_ff  <= 1'b1;
      bor_d_ff  <= 1'b1;
      ext_d_ff  <= 1'b0;
      swr_d_ff  <= 1'b0;
      wdt_d_ff  <= 1'b0;
      tick_d_ff <= 1'b0;
    end else begin
      por_d_ff  <= por_s;
      bor_d_ff  <= bor_s;
      ext_d_ff  <= ext_s;
      swr_d_ff  <= swr_s;
      wdt_d_ff  <= wdt_s;
      tick_d_ff <= tick_s;
    end
  end

  logic cold_hold, warm_evt, ext_evt, swr_evt, wdt_evt, tick_evt;
  logic por_rise, bor_rise;
  assign por_rise  = por_s & ~por_d_ff;
  assign bor_rise  = bor_s & ~bor_d_ff;
  assign cold_hold = por_s | bor_s;
  assign ext_evt   = ext_s & ~ext_d_ff;
  assign swr_evt   = swr_s & ~swr_d_ff;
  assign wdt_evt   = wdt_s & ~wdt_d_ff;
  assign warm_evt  = ext_evt | swr_evt | wdt_evt;
  assign tick_evt  = tick_s & ~tick_d_ff;

  // ==========================================================================
  // Sequencer.
  // The stages run strictly in order: detector extension, power-up delay,
  // oscillator start-up, start-up timer, PLL lock and then run.
  // A detector that reads active at any time sends the machine back to the
  // extension stage, so every return of the supply restarts the whole delay.
  // A warm reset source skips the supply stages and restarts at the
  // oscillator stage, keeping the clock source that is already running.
  // One shared counter serves every stage; it is cleared on each change of
  // stage, so each stage counts from zero.
  rsq_state_type state_ff, nxt_state;
  logic [31:0]   cnt_ff, nxt_cnt;
  logic          cold_ff;
  logic          is_por_ff;
  rsq_osc_type   mode;
  logic [31:0]   power_up_timer_cyc, oscd_cyc;

  assign mode = rsq_osc_type'(current_clock_select);

  // [R10] Eight power-up delays.
  always_comb begin
    case (power_up_delay_select)
      3'd0:    power_up_timer_cyc = 32'd0;
      default: power_up_timer_cyc = (32'd1 << power_up_delay_select) * MS_CYCLES;
    endcase
  end

  // [R11] Start-up delay by mode.
  always_comb begin
    case (mode)
      OSC_LPRC: oscd_cyc = OSCD_LPRC_CYC;
      OSC_EC,
      OSC_ECPLL: oscd_cyc = 32'd0;
      default:  oscd_cyc = OSCD_FRC_CYC;
    endcase
  end

  logic needs_ost, needs_lock;
  assign needs_ost  = (mode == OSC_PRI) || (mode == OSC_PRIPLL) ||
                      (mode == OSC_SOSC);
  assign needs_lock = (mode == OSC_FRCPLL) || (mode == OSC_PRIPLL) ||
                      (mode == OSC_ECPLL);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff + 32'd1;
    case (state_ff)
      // [R7] [R8] Extension counted once detector drops.
      ST_EXT: begin
        if ((is_por_ff && cnt_ff + 32'd1 >= POR_EXT_CYC) ||
            (!is_por_ff && cnt_ff + 32'd1 >= BOR_EXT_CYC)) begin
          nxt_state = ST_POWER_UP_TIMER;
          nxt_cnt   = 32'd0;
        end
      end
      // [R9] Power-up delay holds reset.
      ST_POWER_UP_TIMER: begin
        if (cnt_ff >= power_up_timer_cyc) begin
          nxt_state = ST_OSCD;
          nxt_cnt   = 32'd0;
        end
      end
      ST_OSCD: begin
        if (cnt_ff >= oscd_cyc) begin
          nxt_state = needs_ost ? ST_OST : (needs_lock ? ST_LOCK : ST_RUN);
          nxt_cnt   = 32'd0;
        end
      end
      // [R12] Count oscillator periods.
      ST_OST: begin
        nxt_cnt = cnt_ff + {31'd0, tick_evt};
        if (cnt_ff >= OST_PERIODS) begin
          nxt_state = needs_lock ? ST_LOCK : ST_RUN;
          nxt_cnt   = 32'd0;
        end
      end
      // [R13] PLL lock wait.
      ST_LOCK: begin
        if (cnt_ff + 32'd1 >= LOCK_CYCLES) begin
          nxt_state = ST_RUN;
          nxt_cnt   = 32'd0;
        end
      end
      ST_RUN: begin
        nxt_cnt = (cnt_ff < FAIL_SAFE_CLOCK_MONITOR_CYCLES) ? cnt_ff + 32'd1 : cnt_ff;
      end
      default: begin
        nxt_state = ST_EXT;
        nxt_cnt   = 32'd0;
      end
    endcase
    // [R16] [R19] Cold cause returns to first stage.
    if (cold_hold) begin
      nxt_state = ST_EXT;
      nxt_cnt   = 32'd0;
    end else if (warm_evt) begin
      nxt_state = ST_OSCD;
      nxt_cnt   = 32'd0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_EXT;
      cnt_ff   <= 32'd0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // Remember which detector started the cold sequence.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      is_por_ff <= 1'b1;
      cold_ff   <= 1'b1;
    end else if (por_s) begin
      is_por_ff <= 1'b1;
      cold_ff   <= 1'b1;
    end else if (bor_s) begin
      is_por_ff <= 1'b0;
      cold_ff   <= 1'b1;
    end else if (warm_evt) begin
      cold_ff <= 1'b0;
    end
  end

  // [R5] [R6] Clock source selection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      current_clock_select <= 3'h0;
    else if (cold_hold || (cold_ff && state_ff == ST_POWER_UP_TIMER))
      current_clock_select <= initial_clock_select;
  end

  logic run_n;
  assign run_n = (nxt_state != ST_RUN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_reset            <= 1'b1;
      clock_ready             <= 1'b0;
      fetch_start             <= 1'b0;
      fetch_addr              <= RESET_VECTOR;
      fail_safe_clock_monitor <= 1'b0;
    end else begin
      // [R17] [R9] Cold sources hold reset until the delays expire; a warm event asserts it for one cycle.
      system_reset <= cold_hold || warm_evt ||
                      nxt_state == ST_EXT || nxt_state == ST_POWER_UP_TIMER;
      clock_ready  <= !run_n;
      // [R14] Fetch begins from the reset vector.
      fetch_start  <= !run_n && state_ff != ST_RUN;
      fetch_addr   <= RESET_VECTOR;
      // [R15] Monitor after extra delay.
      fail_safe_clock_monitor <= fail_safe_clock_monitor_enable && state_ff == ST_RUN &&
                                 nxt_state == ST_RUN &&
                                 cnt_ff + 32'd1 >= FAIL_SAFE_CLOCK_MONITOR_CYCLES;
    end
  end

  // ==========================================================================
  // Cause register and APB.
  // The cause flags record history and bit 5 enables the watchdog: a write stores the masked word and
  // never starts a reset. A detector or reset event in the same cycle as a
  // write takes priority, so software cannot hide a fresh cause.
  // The APB slave answers with no wait states: read data and the ready pulse
  // are registered in the setup cycle and stand in the access cycle.
  logic [15:0] cause_ff;
  logic [3:0]  irq_st_ff, irq_mk_ff, ev;
  logic        wr, rd;
  logic [15:0] wdat;
  assign wr   = psel && penable && pwrite;
  assign rd   = psel && penable && !pwrite;
  assign wdat = pwdata[15:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_ff <= CAUSE_RESET;
    end else begin
      // [R3] Writes only store flags.
      if (wr && paddr == ADDR_CAUSE)
        cause_ff <= wdat & CAUSE_WMASK;
      // [R18] Power-on clears all but the power-on and brown-out flags.
      if (por_rise) begin
        cause_ff          <= 16'h0000;
        cause_ff[BIT_POR] <= 1'b1;
        cause_ff[BIT_BOR] <= 1'b1;
      end else if (bor_rise) begin
        cause_ff <= (cause_ff & BOR_KEEP) | (16'h0001 << BIT_BOR);
      end else begin
        // [R1] [R2] Detectors set flags; hardware wins over writes.
        if (por_s)
          cause_ff[BIT_POR] <= 1'b1;
        if (bor_s)
          cause_ff[BIT_BOR] <= 1'b1;
        if (ext_evt)
          cause_ff[BIT_EXTR] <= 1'b1;
        if (swr_evt)
          cause_ff[BIT_SWR] <= 1'b1;
        if (wdt_evt)
          cause_ff[BIT_WDTO] <= 1'b1;
      end
    end
  end

  assign ev = {bor_rise, fail_safe_clock_monitor == 1'b0 &&
               nxt_state == ST_RUN && fail_safe_clock_monitor_enable &&
               cnt_ff + 32'd1 == FAIL_SAFE_CLOCK_MONITOR_CYCLES,
               !run_n && state_ff != ST_RUN,
               system_reset && !(cold_hold || warm_evt ||
               nxt_state == ST_EXT || nxt_state == ST_POWER_UP_TIMER)};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_ff <= 4'h0;
      irq_mk_ff <= 4'h0;
    end else begin
      if (wr && paddr == ADDR_IRQ_MK)
        irq_mk_ff <= pwdata[3:0];
      // Read clears; a new event in the same cycle stays set.
      irq_st_ff <= ((rd && paddr == ADDR_IRQ_ST) ? 4'h0 : irq_st_ff) | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(irq_st_ff & irq_mk_ff);
  end

  // [R4] Fuse forces watchdog on.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      watchdog_enable <= 1'b1;
    else
      watchdog_enable <= watchdog_fuse_enable | cause_ff[BIT_SOFT_WATCHDOG_ENABLE];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        case (paddr)
          ADDR_CAUSE:  prdata <= {16'h0000, cause_ff};
          ADDR_STATUS: prdata <= {24'h00_0000, clock_ready, system_reset,
                                  current_clock_select, state_ff};
          ADDR_IRQ_ST: prdata <= {28'h000_0000, irq_st_ff};
          ADDR_IRQ_MK: prdata <= {28'h000_0000, irq_mk_ff};
          default:     pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule : rsq_top

// ### logic/rsq_pkg.sv
// Package of constants for the reset sequencer with cause flags.
// How it works
// [R1] Brown-out sets cause flag bit 1
// [R2] Power-on sets cause flag bit 0
// [R3] Software writes flags, never causes reset
// [R4] Watchdog fuse one forces watchdog enabled
// [R5] Cold reset loads initial clock select
// [R6] Warm reset keeps current clock select
// [R7] Power-on extension at most 30 us
// [R8] Brown-out extension at most 100 us
// [R9] Power-up delay then system reset released
// [R10] Three-bit select, eight delays 0..128 ms
// [R11] Clock-ready delay depends on oscillator mode
// [R12] Start-up timer counts 1024 oscillator periods
// [R13] PLL lock wait of 1.5 ms
// [R14] Fetch starts at address zero
// [R15] Monitor starts 900 us after clock ready
// [R16] Each supply return restarts extension and delay
// [R17] Any reset source asserts system reset
// [R18] Power-on clears all flags except power-on; the code also sets brown-out
// [R19] Stages in order; cold cause restarts
package rsq_pkg;

  // ==========================================================================
  // Clock and timing.
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned POR_EXT_NS      = 30_000;
  localparam int unsigned BOR_EXT_NS      = 100_000;
  localparam int unsigned LOCK_NS         = 1_500_000;
  localparam int unsigned FAIL_SAFE_CLOCK_MONITOR_NS         = 900_000;
  localparam int unsigned OSCD_FRC_NS     = 1_100;
  localparam int unsigned OSCD_LPRC_NS    = 70_000;
  localparam int unsigned CLK_NS          = 1_000_000_000 / CLK_HZ;
  localparam int unsigned POR_EXT_CYC     = POR_EXT_NS / CLK_NS;
  localparam int unsigned BOR_EXT_CYC     = BOR_EXT_NS / CLK_NS;
  localparam int unsigned LOCK_CYC        = LOCK_NS / CLK_NS;
  localparam int unsigned FAIL_SAFE_CLOCK_MONITOR_CYC        = FAIL_SAFE_CLOCK_MONITOR_NS / CLK_NS;
  localparam int unsigned OSCD_FRC_CYC    = OSCD_FRC_NS / CLK_NS;
  localparam int unsigned OSCD_LPRC_CYC   = OSCD_LPRC_NS / CLK_NS;
  localparam int unsigned OST_PERIODS     = 1024;
  localparam int unsigned MS_CYC          = 1_000_000 / CLK_NS;

  // ==========================================================================
  // Register map (byte addresses).
  localparam logic [7:0] ADDR_CAUSE  = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_ST = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MK = 8'h0c;

  // Cause register fields.
  localparam int unsigned BIT_POR    = 0;
  localparam int unsigned BIT_BOR    = 1;
  localparam int unsigned BIT_SOFT_WATCHDOG_ENABLE = 5;
  localparam int unsigned BIT_SWR    = 6;
  localparam int unsigned BIT_EXTR   = 7;
  localparam int unsigned BIT_WDTO   = 4;
  localparam logic [15:0] CAUSE_RESET  = 16'h0003;
  localparam logic [15:0] CAUSE_WMASK  = 16'hc3ff;
  // External resets keep their flag through a brown-out.
  localparam logic [15:0] BOR_KEEP     = 16'h0080;

  // Interrupt event bits.
  localparam int unsigned IRQ_RELEASE = 0;
  localparam int unsigned IRQ_CLKRDY  = 1;
  localparam int unsigned IRQ_FAIL_SAFE_CLOCK_MONITOR    = 2;
  localparam int unsigned IRQ_BOR     = 3;

  localparam logic [23:0] RESET_VECTOR = 24'h00_0000;

  // Oscillator modes on the three-bit clock select.
  typedef enum logic [2:0] {
    OSC_FRC    = 3'h0,
    OSC_FRCPLL = 3'h1,
    OSC_PRI    = 3'h2,
    OSC_PRIPLL = 3'h3,
    OSC_SOSC   = 3'h4,
    OSC_LPRC   = 3'h5,
    OSC_EC     = 3'h6,
    OSC_ECPLL  = 3'h7
  } rsq_osc_type;

  typedef enum logic [2:0] {
    ST_EXT  = 3'b000,
    ST_POWER_UP_TIMER = 3'b001,
    ST_OSCD = 3'b010,
    ST_OST  = 3'b011,
    ST_LOCK = 3'b100,
    ST_RUN  = 3'b101
  } rsq_state_type;

endpackage : rsq_pkg

// ### testbench/rsq_assertions.sv
// Port checker for the reset sequencer with its bind.
`timescale 1ns/10ps
module rsq_assertions
  import rsq_pkg::*;
#(
  parameter int unsigned MS_CYCLES   = MS_CYC,
  parameter int unsigned LOCK_CYCLES = LOCK_CYC,
  parameter int unsigned FAIL_SAFE_CLOCK_MONITOR_CYCLES = FAIL_SAFE_CLOCK_MONITOR_CYC
) (
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // Causes and configuration.
  input wire logic        por_active,
  input wire logic        bor_active,
  input wire logic        soft_reset,
  input wire logic [2:0]  power_up_delay_select,
  input wire logic        watchdog_fuse_enable,
  input wire logic        fail_safe_clock_monitor_enable,
  // Sequencer outputs.
  input wire logic        system_reset,
  input wire logic        clock_ready,
  input wire logic        fetch_start,
  input wire logic [23:0] fetch_addr,
  input wire logic        fail_safe_clock_monitor,
  input wire logic        watchdog_enable,
  input wire logic [2:0]  current_clock_select
);
  // ==========================================================================
  // Helper counters.
  int unsigned low_cnt_ff;
  int unsigned rel_cnt_ff;
  int unsigned rdy_cnt_ff;
  logic        bor_last_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_ff  <= 0;
      rel_cnt_ff  <= 0;
      rdy_cnt_ff  <= 0;
      bor_last_ff <= 1'b0;
    end else begin
      low_cnt_ff  <= (por_active || bor_active) ? 0 : low_cnt_ff + 1;
      rel_cnt_ff  <= system_reset ? 0 : rel_cnt_ff + 1;
      rdy_cnt_ff  <= clock_ready ? rdy_cnt_ff + 1 : 0;
      bor_last_ff <= bor_active ? 1'b1 : por_active ? 1'b0 : bor_last_ff;
    end
  end

  function automatic int unsigned ext_min(input logic b, input logic [2:0] s);
    return (b ? BOR_EXT_CYC : POR_EXT_CYC) +
           (s == 3'h0 ? 0 : (1 << s) * MS_CYCLES);
  endfunction : ext_min

  function automatic int unsigned osc_min(input logic [2:0] c);
    int unsigned t;
    t = (c == OSC_EC || c == OSC_ECPLL) ? 0 :
        (c == OSC_LPRC) ? OSCD_LPRC_CYC : OSCD_FRC_CYC;
    if (c inside {OSC_PRI, OSC_PRIPLL, OSC_SOSC}) t += 8 * (OST_PERIODS - 1);
    if (c inside {OSC_FRCPLL, OSC_PRIPLL, OSC_ECPLL}) t += LOCK_CYCLES;
    return t;
  endfunction : osc_min

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_por_hold; por_active [*6] |-> system_reset; endproperty
  a_por_hold: assert property (p_por_hold)
    else $error("reset released under power-on detector");
  property p_bor_hold; bor_active [*6] |-> system_reset; endproperty
  a_bor_hold: assert property (p_bor_hold)
    else $error("reset released under brown-out detector");
  property p_ext_time;
    $fell(system_reset) |-> low_cnt_ff >=
      ext_min(bor_last_ff, power_up_delay_select);
  endproperty
  a_ext_time: assert property (p_ext_time)
    else $error("reset released before extension and delay");
  property p_osc_time;
    $rose(clock_ready) |-> rel_cnt_ff + 1 >= osc_min(current_clock_select);
  endproperty
  a_osc_time: assert property (p_osc_time)
    else $error("clock ready too early for mode");
  property p_fetch;
    $rose(clock_ready) |-> fetch_start && fetch_addr == 24'h00_0000;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("no fetch from address zero at clock ready");
  property p_order; clock_ready |-> !system_reset; endproperty
  a_order: assert property (p_order)
    else $error("clock ready while in reset");
  property p_fail_safe_clock_monitor_early;
    $rose(fail_safe_clock_monitor) |-> fail_safe_clock_monitor_enable && clock_ready &&
      rdy_cnt_ff + 1 >= FAIL_SAFE_CLOCK_MONITOR_CYCLES;
  endproperty
  a_fail_safe_clock_monitor_early: assert property (p_fail_safe_clock_monitor_early)
    else $error("monitor started early");
  property p_fail_safe_clock_monitor_late;
    fail_safe_clock_monitor_enable && rdy_cnt_ff == FAIL_SAFE_CLOCK_MONITOR_CYCLES + 3 |-> fail_safe_clock_monitor;
  endproperty
  a_fail_safe_clock_monitor_late: assert property (p_fail_safe_clock_monitor_late)
    else $error("monitor not started in time");
  property p_wdt; watchdog_fuse_enable [*3] |-> watchdog_enable; endproperty
  a_wdt: assert property (p_wdt)
    else $error("watchdog off with fuse set");
  property p_warm_sel;
    $rose(soft_reset) && clock_ready |=> $stable(current_clock_select) [*8];
  endproperty
  a_warm_sel: assert property (p_warm_sel)
    else $error("clock select changed on warm reset");
  property p_warm_rst;
    $rose(soft_reset) && clock_ready |-> ##[1:8] system_reset;
  endproperty
  a_warm_rst: assert property (p_warm_rst)
    else $error("software reset did not reset");

  c_fail_safe_clock_monitor: cover property ($rose(fail_safe_clock_monitor));
  c_xtal: cover property (fetch_start && current_clock_select == OSC_PRI);
  c_bor: cover property ($fell(system_reset) && bor_last_ff);
endmodule : rsq_assertions

bind rsq_top rsq_assertions #(
  .MS_CYCLES(MS_CYCLES), .LOCK_CYCLES(LOCK_CYCLES), .FAIL_SAFE_CLOCK_MONITOR_CYCLES(FAIL_SAFE_CLOCK_MONITOR_CYCLES)
) u_rsq_chk (
  .pclk(pclk), .presetn(presetn), .por_active(por_active),
  .bor_active(bor_active), .soft_reset(soft_reset),
  .power_up_delay_select(power_up_delay_select),
  .watchdog_fuse_enable(watchdog_fuse_enable), .fail_safe_clock_monitor_enable(fail_safe_clock_monitor_enable),
  .system_reset(system_reset), .clock_ready(clock_ready),
  .fetch_start(fetch_start), .fetch_addr(fetch_addr),
  .fail_safe_clock_monitor(fail_safe_clock_monitor),
  .watchdog_enable(watchdog_enable),
  .current_clock_select(current_clock_select)
);

// ### testbench/test_reset_sequencer_cause_flags.sv
// Self-checking bench for the reset sequencer.
`timescale 1ns/10ps
module test_reset_sequencer_cause_flags
  import rsq_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        por_active, bor_active, ext_reset, soft_reset, wdt_timeout;
  logic        osc_tick, watchdog_fuse_enable, fail_safe_clock_monitor_enable, irq;
  logic [2:0]  initial_clock_select, power_up_delay_select;
  logic [2:0]  current_clock_select;
  logic        system_reset, clock_ready, fetch_start;
  logic        fail_safe_clock_monitor, watchdog_enable;
  logic [23:0] fetch_addr;
  int          num_errors, checks, seed;
  logic [32:0] exq[$];
  logic [31:0] mkq[$];

  rsq_top #(.MS_CYCLES(10), .LOCK_CYCLES(20), .FAIL_SAFE_CLOCK_MONITOR_CYCLES(30)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .por_active, .bor_active, .ext_reset, .soft_reset,
    .wdt_timeout, .osc_tick, .initial_clock_select, .power_up_delay_select,
    .watchdog_fuse_enable, .fail_safe_clock_monitor_enable, .system_reset, .clock_ready,
    .fetch_start, .fetch_addr, .fail_safe_clock_monitor, .watchdog_enable,
    .current_clock_select, .irq
  );

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    osc_tick = 1'b0;
    forever begin
      repeat (5) @(posedge pclk);
      osc_tick <= ~osc_tick;
    end
  end

  // ==========================================================================
  // Checking and closing.
  task automatic chk(input string n, input logic [32:0] e, input logic [32:0] s);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task end_sim;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  always @(posedge pclk) begin
    logic [31:0] m;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      m = mkq.pop_front();
      chk("read", exq.pop_front() & {1'b1, m}, {pslverr, prdata} & {1'b1, m});
    end
  end

  // ==========================================================================
  // Bus and wait tasks.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e = 0,
                     input logic [31:0] m = 32'hffff_ffff);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    if (!w) begin
      exq.push_back(e);
      mkq.push_back(m);
    end
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      num_errors++;
      end_sim;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // Two edges let registered side effects settle before direct checks.
    repeat (2) @(posedge pclk);
  endtask : apb

  task automatic wait_fetch(input int lim);
    int n;
    n = 0;
    while (fetch_start !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (n >= lim) begin
      num_errors++;
      end_sim;
    end
  endtask : wait_fetch

  // ==========================================================================
  // Main sequence.
  initial begin
    logic [31:0] d;
    seed = 73867;
    num_errors = 0;
    checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    por_active = 1'b1;
    bor_active = 1'b0;
    ext_reset = 1'b0;
    soft_reset = 1'b0;
    wdt_timeout = 1'b0;
    initial_clock_select = OSC_FRCPLL;
    power_up_delay_select = 3'h1;
    watchdog_fuse_enable = 1'b1;
    fail_safe_clock_monitor_enable = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (20) @(posedge pclk);
    por_active <= 1'b0;
    wait_fetch(1000);
    chk("clksel", OSC_FRCPLL, current_clock_select);
    chk("wdt", 1, watchdog_enable);
    repeat (40) @(posedge pclk);
    chk("fail_safe_clock_monitor", 1, fail_safe_clock_monitor);
    apb(0, ADDR_CAUSE, 0, 32'h0000_0003);
    apb(1, ADDR_STATUS, 32'hffff_ffff);
    apb(0, ADDR_STATUS, 0, {24'h00_0000, 2'b10, OSC_FRCPLL, ST_RUN});
    apb(1, ADDR_IRQ_MK, 0);
    chk("irq", 0, irq);
    apb(1, ADDR_IRQ_MK, 32'h0000_0007);
    chk("irq", 1, irq);
    apb(0, ADDR_IRQ_ST, 0, 32'h0000_0007, 32'h0000_0007);
    chk("irq", 0, irq);
    apb(0, 8'h10, 0, {1'b1, 32'h0000_0000});
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      apb(1, ADDR_CAUSE, d);
      apb(0, ADDR_CAUSE, 0, d & 32'h0000_c3ff);
      chk("system_reset", 0, system_reset);
    end
    watchdog_fuse_enable <= 1'b0;
    apb(1, ADDR_CAUSE, 0);
    chk("wdt", 0, watchdog_enable);
    apb(1, ADDR_CAUSE, 32'h0000_0020);
    chk("wdt", 1, watchdog_enable);
    apb(1, ADDR_CAUSE, 0);
    initial_clock_select <= OSC_EC;
    soft_reset <= 1'b1;
    repeat (4) @(posedge pclk);
    soft_reset <= 1'b0;
    wait_fetch(500);
    chk("clksel", OSC_FRCPLL, current_clock_select);
    apb(0, ADDR_CAUSE, 0, 32'h0000_0040);
    apb(0, ADDR_IRQ_ST, 0, 32'h0000_0003, 32'h0000_0003);
    initial_clock_select <= OSC_PRI;
    bor_active <= 1'b1;
    repeat (20) @(posedge pclk);
    chk("system_reset", 1, system_reset);
    bor_active <= 1'b0;
    repeat (400) @(posedge pclk);
    bor_active <= 1'b1;
    repeat (20) @(posedge pclk);
    bor_active <= 1'b0;
    repeat (1000) @(posedge pclk);
    chk("system_reset", 1, system_reset);
    wait_fetch(20000);
    chk("clksel", OSC_PRI, current_clock_select);
    apb(0, ADDR_CAUSE, 0, 32'h0000_0002);
    apb(0, ADDR_IRQ_ST, 0, 32'h0000_000b, 32'h0000_000b);
    end_sim;
  end
endmodule : test_reset_sequencer_cause_flags
